// file: smc_sleep_ctrl.sv
// sleep mode controller: entry, wake, clock gating, rail control, flags
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int AEN_WIDTH = AEN_W
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [7:0] wb_adr_i, // wishbone address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic sleep_exec_i, // decoder: sleep instruction executing
    input wire smc_irq_type irq_flag_i, // wake-capable interrupt flags
    input wire logic por_i, // power-on reset event
    input wire logic external_reset_pin_i, // external reset pin event
    input wire logic wdt_timeout_i, // watchdog expiry event
    output logic wdt_clear_o, // clear watchdog and prescaler
    output logic wdt_run_o, // watchdog allowed to count
    output logic cpu_clk_en_o, // cpu clock enable
    output logic analog_rail_en_o, // analog supply rail request
    output logic [AEN_WIDTH-1:0] analog_en_o, // analog block enables
    output logic conv_ok_o, // converter usable
    output logic io_hold_o, // latch io drive state
    output logic prefetch_o, // prefetch instruction at pc + 1
    output logic resume_o, // resume execution pulse
    output logic vector_isr_o, // vector to service routine after next instr
    output logic core_reset_o, // reset the device
    output logic power_down_flag_o, // status: power down flag
    output logic watchdog_expiry_flag_o // status: watchdog expiry flag
);
    smc_state_type state_reg, state_next;
    logic [31:0] ctrl_reg;
    logic [1:0] irq_en_reg;
    logic [1:0] status_reg;
    smc_power_type pwr_reg;
    logic wake_src, reset_wake, irq_pend, wb_req, wb_wr;

    // only pin change and external edge count, each behind its own enable
    assign irq_pend = (irq_flag_i.pin_change & irq_en_reg[1])
        | (irq_flag_i.ext_edge & irq_en_reg[0]);
    assign reset_wake = por_i | (external_reset_pin_i & ctrl_reg[CTRL_EXTERNAL_RESET_PIN_EN_BIT]);
    assign wake_src = reset_wake | irq_pend
        | (wdt_timeout_i & ctrl_reg[CTRL_WDT_EN_BIT]);
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i;

    // sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_exec_i && !irq_pend) begin
                    state_next = ST_ENTER;
                end
            end
            ST_ENTER: begin
                state_next = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_src) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
        end else if (state_reg == ST_SLEEP && reset_wake) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // registers over wishbone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            irq_en_reg <= IRQ_EN_RESET;
        end else if (wb_wr && wb_adr_i == CTRL_ADDR) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    ctrl_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                end
            end
        end else if (wb_wr && wb_adr_i == IRQ_EN_ADDR && wb_sel_i[0]) begin
            irq_en_reg <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_DATA;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == STATUS_ADDR) begin
                    wb_dat_o <= {30'h0, status_reg};
                end else if (wb_adr_i == CTRL_ADDR) begin
                    wb_dat_o <= ctrl_reg;
                end else if (wb_adr_i == IRQ_EN_ADDR) begin
                    wb_dat_o <= {30'h0, irq_en_reg};
                end else if (wb_adr_i == STATE_ADDR) begin
                    wb_dat_o <= {28'h0, pwr_reg};
                end else begin
                    wb_dat_o <= UNMAPPED_DATA;
                end
            end
        end
    end

    // status flags: sleep entry (ST_ENTER) and wishbone writes update them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= STATUS_RESET;
        end else if (state_reg == ST_ENTER) begin
            status_reg[STAT_PD_BIT] <= 1'b0;
            status_reg[STAT_WDT_BIT] <= 1'b1;
        end else if (wb_wr && wb_adr_i == STATUS_ADDR && wb_sel_i[0]) begin
            status_reg <= wb_dat_i[1:0];
        end
    end

    // power, clock and io hold controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg <= '{cpu_clk_en: 1'b1, analog_rail_en: 1'b1, io_hold: 1'b0,
                conv_ok: 1'b1};
        end else begin
            case (state_next)
                ST_ENTER, ST_SLEEP: begin
                    pwr_reg.cpu_clk_en <= 1'b0;
                    pwr_reg.analog_rail_en <= 1'b0;
                    pwr_reg.io_hold <= 1'b1;
                    pwr_reg.conv_ok <= ctrl_reg[CTRL_REF_BIT] != REF_ANALOG;
                end
                ST_WAKE: begin
                    pwr_reg.analog_rail_en <= 1'b1;
                    pwr_reg.cpu_clk_en <= 1'b1;
                    pwr_reg.io_hold <= 1'b1;
                    pwr_reg.conv_ok <= 1'b1;
                end
                default: begin
                    pwr_reg <= '{cpu_clk_en: 1'b1, analog_rail_en: 1'b1, io_hold: 1'b0,
                        conv_ok: 1'b1};
                end
            endcase
            if (state_reg == ST_SLEEP && reset_wake) begin
                pwr_reg <= '{cpu_clk_en: 1'b1, analog_rail_en: 1'b1, io_hold: 1'b0,
                    conv_ok: 1'b1};
            end
        end
    end

    // core handshakes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_o <= 1'b0;
            wdt_run_o <= 1'b1;
            prefetch_o <= 1'b0;
            resume_o <= 1'b0;
            vector_isr_o <= 1'b0;
            core_reset_o <= 1'b0;
        end else begin
            wdt_clear_o <= (state_next == ST_ENTER)
                || (state_reg == ST_SLEEP && wake_src);
            wdt_run_o <= (state_next == ST_SLEEP || state_next == ST_ENTER) ?
                ctrl_reg[CTRL_WDT_SLEEP_BIT] : 1'b1;
            prefetch_o <= sleep_exec_i && state_reg == ST_RUN;
            resume_o <= state_reg == ST_WAKE;
            vector_isr_o <= state_reg == ST_WAKE && irq_pend
                && ctrl_reg[CTRL_GIE_BIT];
            core_reset_o <= state_reg == ST_SLEEP && reset_wake;
        end
    end

    assign cpu_clk_en_o = pwr_reg.cpu_clk_en;
    assign analog_rail_en_o = pwr_reg.analog_rail_en;
    assign io_hold_o = pwr_reg.io_hold;
    assign conv_ok_o = pwr_reg.conv_ok;
    assign analog_en_o = ctrl_reg[CTRL_AEN_LSB +: AEN_WIDTH];
    assign power_down_flag_o = status_reg[STAT_PD_BIT];
    assign watchdog_expiry_flag_o = status_reg[STAT_WDT_BIT];
endmodule
`default_nettype wire

// file: smc_pkg.sv
// package for the sleep mode controller: register map, fields, constants
package smc_pkg;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] IRQ_EN_ADDR = 8'h08;
    localparam logic [7:0] STATE_ADDR = 8'h0c;
    // status register fields
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_WDT_BIT = 1;
    // control register fields
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_WDT_SLEEP_BIT = 1;
    localparam int CTRL_EXTERNAL_RESET_PIN_EN_BIT = 2;
    localparam int CTRL_WDT_EN_BIT = 3;
    localparam int CTRL_REF_BIT = 4;
    localparam int CTRL_AEN_LSB = 8;
    localparam int AEN_W = 8;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0014;
    localparam logic [1:0] STATUS_RESET = 2'h1;
    localparam logic [1:0] IRQ_EN_RESET = 2'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // reference selection: 1 selects the analog rail (default)
    localparam logic REF_ANALOG = 1'b1;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_SLEEP,
        ST_WAKE
    } smc_state_type;

    typedef struct packed {
        logic pin_change;
        logic ext_edge;
    } smc_irq_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic analog_rail_en;
        logic io_hold;
        logic conv_ok;
    } smc_power_type;
endpackage

// file: smc_sleep_ctrl_props.sv
// checker for the sleep controller port behaviour
`timescale 1ns/1ps
`default_nettype none
module smc_props (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic sleep_exec_i, // sleep op
    input wire logic por_i, // power-on
    input wire logic external_reset_pin_i, // reset pin
    input wire logic wdt_clear_o, // wdt clear
    input wire logic cpu_clk_en_o, // clock en
    input wire logic analog_rail_en_o, // rail
    input wire logic io_hold_o, // io hold
    input wire logic prefetch_o, // prefetch
    input wire logic resume_o, // resume
    input wire logic vector_isr_o, // vector
    input wire logic core_reset_o, // reset out
    input wire logic power_down_flag_o, // pd
    input wire logic watchdog_expiry_flag_o // to
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_sleep_only_cmd: assert property (cpu_clk_en_o && !sleep_exec_i |=> cpu_clk_en_o)
        else $error("clock gated without sleep");
    a_rail_with_clk: assert property (analog_rail_en_o == cpu_clk_en_o)
        else $error("rail and clock differ");
    a_hold_asleep: assert property (!cpu_clk_en_o |-> io_hold_o) else $error("io not held");
    a_entry_clear: assert property ($fell(cpu_clk_en_o) |-> wdt_clear_o && prefetch_o)
        else $error("entry without clear");
    a_entry_flags: assert property ($fell(cpu_clk_en_o) |=> !power_down_flag_o && watchdog_expiry_flag_o)
        else $error("flags not updated");
    a_wake_clear: assert property ($rose(cpu_clk_en_o) && !$past(por_i) && !$past(external_reset_pin_i)
        |-> wdt_clear_o ##1 resume_o) else $error("wake sequence wrong");
    a_reset_wake: assert property (!cpu_clk_en_o && !$past(cpu_clk_en_o) && por_i |=> core_reset_o)
        else $error("por did not reset");
    c_sleep: cover property ($fell(cpu_clk_en_o));
    c_vector: cover property (resume_o && vector_isr_o);
    c_reset: cover property (core_reset_o);
endmodule
bind smc_sleep_ctrl smc_props u_props (.*);
`default_nettype wire

// file: smc_cpu_model.sv
// core decoder and interrupt flag model
`timescale 1ns/1ps
`default_nettype none
module smc_cpu_model
    import smc_pkg::*;
(
    input wire logic clk_i, // core clock
    output var logic sleep_exec_o, // sleep in execute
    output var smc_irq_type irq_o // irq flag levels
);
    initial begin
        sleep_exec_o = 1'h0;
        irq_o = '0;
    end
    // one execute slot; the program puts a no_operation after it
    task exec_sleep();
        @(posedge clk_i);
        sleep_exec_o <= 1'h1;
        @(posedge clk_i);
        sleep_exec_o <= 1'h0;
    endtask
    task set_irq(input smc_irq_type v);
        @(posedge clk_i);
        irq_o <= v;
    endtask
endmodule
`default_nettype wire

// file: smc_sleep_ctrl_tb.sv
// testbench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_tb;
    import smc_pkg::*;
    logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, por = 0, external_reset_pin = 0, wdt = 0;
    logic sx, ack, wclr, wrun, clk_en, rail, conv, hold, pref, res, vec, crst, pd, to;
    logic [7:0] adr = 0, aen;
    logic [31:0] dat = 0, rdo, rdat;
    smc_irq_type irq;
    int fails = 0, tests_run = 0, cyc_n = 0;
    always #12.5 clk_i = ~clk_i;
    smc_cpu_model cpu (.clk_i(clk_i), .sleep_exec_o(sx), .irq_o(irq));
    smc_sleep_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdo), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .sleep_exec_i(sx), .irq_flag_i(irq), .por_i(por), .external_reset_pin_i(external_reset_pin),
        .wdt_timeout_i(wdt), .wdt_clear_o(wclr), .wdt_run_o(wrun), .cpu_clk_en_o(clk_en),
        .analog_rail_en_o(rail), .analog_en_o(aen), .conv_ok_o(conv), .io_hold_o(hold),
        .prefetch_o(pref), .resume_o(res), .vector_isr_o(vec), .core_reset_o(crst),
        .power_down_flag_o(pd), .watchdog_expiry_flag_o(to));
    task wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        rdat = rdo;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            fails++;
            $display("wrong value at %0t: timeout", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(0, CTRL_ADDR, 0);
        chk(rdat, CTRL_RESET, "ctrl reset");
        wb(0, STATUS_ADDR, 0);
        chk(rdat, 32'h1, "status reset");
        wb(0, STATE_ADDR, 0);
        chk(rdat, 32'hd, "state reset");
        wb(0, 8'h10, 0);
        chk(rdat, UNMAPPED_DATA, "unmapped");
        $display("test registers done");
        wb(1, IRQ_EN_ADDR, 32'h1);
        cpu.set_irq(2'h1);
        cpu.exec_sleep();
        repeat (2) @(posedge clk_i);
        chk({clk_en, pd, to}, 32'h6, "pending sleep");
        cpu.set_irq(2'h0);
        wb(0, STATUS_ADDR, 0);
        chk(rdat, 32'h1, "pd after nop");
        $display("test pending done");
        for (int i = 0; i < 5; i++) begin
            wb(1, CTRL_ADDR, 32'ha51c | 32'(i == 1));
            wb(1, IRQ_EN_ADDR, (i == 1) ? 32'h1 : 32'h2);
            cpu.set_irq((i == 1) ? 2'h2 : 2'h1);
            cpu.exec_sleep();
            repeat (3) @(posedge clk_i);
            chk({pd, to, clk_en, rail, hold, conv, aen}, 32'h12a5, "asleep");
            chk(wrun, 32'h0, "watchdog stopped in sleep");
            wdt <= (i == 2);
            external_reset_pin <= (i == 3);
            por <= (i == 4);
            if (i < 2) cpu.set_irq(2'h3);
            for (int k = 0; k < 8 && res !== 1'h1 && crst !== 1'h1; k++) @(posedge clk_i);
            chk({res, crst, vec, clk_en}, {i < 3, i > 2, i == 1, 1'h1}, "wake");
            wdt <= 1'h0;
            external_reset_pin <= 1'h0;
            por <= 1'h0;
            cpu.set_irq(2'h0);
            $display("test wake %0d done", i);
        end
        wb(1, STATUS_ADDR, 32'h1);
        wb(1, IRQ_EN_ADDR, 32'h1);
        wb(1, CTRL_ADDR, 32'h1c);
        cpu.exec_sleep();
        cpu.set_irq(2'h1);
        for (int k = 0; k < 8 && res !== 1'h1; k++) @(posedge clk_i);
        chk({res, vec, clk_en, pd, to}, 32'h15, "late irq wake");
        cpu.set_irq(2'h0);
        $display("test late irq done");
        wrap_up();
    end
endmodule
`default_nettype wire
